// ==== logic/slpr_params.svh ====
// register offsets, field positions and reset values of the layout/suspend register bank
// assumes byte addressing on a 32-bit avalon-mm slave, one aligned word per register
`ifndef SLPR_PARAMS_SVH
`define SLPR_PARAMS_SVH

`define SLPR_OFF_SUSPEND      8'h00
`define SLPR_OFF_CFG_NV       8'h04
`define SLPR_OFF_CFG_VOL      8'h08
`define SLPR_OFF_IRQ_STATUS   8'h0c
`define SLPR_OFF_IRQ_MASK     8'h10
`define SLPR_OFF_DEV_STATE    8'h14

`define SLPR_BIT_PROG_SUSP    0
`define SLPR_BIT_ERASE_SUSP   1

`define SLPR_BIT_TLOCK        0
`define SLPR_BIT_TOPBOT       2
`define SLPR_BIT_PLOCK        4
`define SLPR_BIT_HALF         5
`define SLPR_BIT_SPLIT        6

// layout bits frozen by either lock
`define SLPR_LAYOUT_MASK      8'h64
// reserved bits, plain read/write storage
`define SLPR_RSVD_MASK        8'h8a

`define SLPR_IRQ_ERASE_SUSP   0
`define SLPR_IRQ_PROG_SUSP    1
`define SLPR_IRQ_REFUSED      2
`define SLPR_IRQ_W            3

`define SLPR_CFG_NV_RESET     8'h00
`define SLPR_CFG_VOL_RESET    8'h00
`define SLPR_IRQ_MASK_RESET   3'h0

`endif

// ==== logic/slpr_pkg.sv ====
// types used by the layout/suspend register bank, not by its layout decoder
// assumes nothing beyond the params header for field positions
package slpr_pkg;

    typedef logic [7:0] slpr_byte_t;

    // one configuration byte, msb first
    typedef struct packed {
        logic rsvd7;
        logic split;
        logic half;
        logic plock;
        logic rsvd3;
        logic topbot;
        logic rsvd1;
        logic tlock;
    } slpr_cfg_t;

endpackage

// ==== logic/slpr_layout_if.sv ====
// carries the active layout settings from the register bank to the address decoder
// assumes one clock domain; all signals are levels
`timescale 1ns/1ps
`default_nettype none

interface slpr_layout_if;
    logic split_small_sectors;
    logic small_block_top_bottom;
    logic readable_half_select;

    modport regs (output split_small_sectors, output small_block_top_bottom, output readable_half_select);
    modport dec  (input  split_small_sectors, input  small_block_top_bottom, input  readable_half_select);
endinterface

`default_nettype wire

// ==== logic/slpr_layout_decode.sv ====
// classifies a byte address against the active small-sector layout and read-password half
// assumes the address probe and the unlock flag come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module slpr_layout_decode #(
    parameter int ADDR_W       = 26,
    parameter int SMALL_LOG2   = 12,
    parameter int SMALL_COUNT  = 32
) (
    slpr_layout_if.dec              lay,
    input  wire logic [ADDR_W-1:0]  probe_addr,
    input  wire logic               password_ok,
    output logic                    in_small_sector,
    output logic                    readable
);
    localparam logic [ADDR_W-1:0] REGION = ADDR_W'(SMALL_COUNT) << SMALL_LOG2;
    localparam logic [ADDR_W-1:0] HALF_R = REGION >> 1;

    // true when addr lies within span bytes of the bottom or the top of the space
    function automatic logic near_edge(input logic [ADDR_W-1:0] addr,
                                       input logic [ADDR_W-1:0] span,
                                       input logic              top);
        logic [ADDR_W-1:0] inv;
        inv = ~addr;
        near_edge = top ? (inv < span) : (addr < span);
    endfunction

    always_comb
    begin
        if (lay.split_small_sectors)
            in_small_sector = near_edge(probe_addr, HALF_R, 1'b0) | near_edge(probe_addr, HALF_R, 1'b1);
        else
            in_small_sector = near_edge(probe_addr, REGION, lay.small_block_top_bottom);
    end

    // half select 0 keeps the top half open, 1 the bottom half
    assign readable = password_ok | (probe_addr[ADDR_W-1] == ~lay.readable_half_select);

endmodule

`default_nettype wire

// ==== logic/slpr_regs.sv ====
// suspend status and small-sector layout configuration bank of a serial nor flash
// assumes avalon-mm master on clk; suspend, busy and unlock inputs come from logic on clk
//
// Overview of operation
// - erase-suspended flag reads 1 while an erase is suspended, else 0; resets 0.
// - program-suspended flag reads 1 while a program is suspended, else 0; resets 0.
// - split bit 0 groups small sectors together; 1 splits them top and bottom.
// - without password, half bit 0 keeps top half readable, 1 bottom half.
// - permanent lock blocks layout bit changes; the lock bit only sets, never clears.
// - top/bottom bit 0 puts small block at bottom, 1 at top.
// - temporary lock blocks layout changes; only its volatile copy is writable.
// - with split set, the top/bottom bit is ignored.
// - temporary lock without permanent lock lasts only until next power-down.
`timescale 1ns/1ps
`default_nettype none
`include "slpr_params.svh"

module slpr_regs #(
    parameter int ADDR_W      = 26,
    parameter int SMALL_LOG2  = 12,
    parameter int SMALL_COUNT = 32
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic [31:0]             avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic               erase_suspended,
    input  wire logic               program_suspended,
    input  wire logic               device_busy,
    input  wire logic [ADDR_W-1:0]  probe_addr,
    input  wire logic               password_ok,
    output logic                    in_small_sector,
    output logic                    readable,
    output logic                    layout_locked,
    output logic                    irq
);
    slpr_pkg::slpr_cfg_t     cfg_nv_ff;
    slpr_pkg::slpr_cfg_t     cfg_vol_ff;
    slpr_pkg::slpr_cfg_t     nxt_cfg_nv;
    slpr_pkg::slpr_cfg_t     wr_cfg;
    logic                    erase_susp_ff;
    logic                    prog_susp_ff;
    logic                    load_pending_ff;
    logic                    ack_ff;
    logic [31:0]             readdata_ff;
    logic [`SLPR_IRQ_W-1:0]  irq_status_ff;
    logic [`SLPR_IRQ_W-1:0]  irq_mask_ff;
    logic [`SLPR_IRQ_W-1:0]  irq_events;
    logic [`SLPR_IRQ_W-1:0]  irq_clear;
    logic                    req;
    logic                    wr_take;
    logic                    wr_nv;
    logic                    wr_vol;
    logic                    wr_status;
    logic                    wr_mask;
    logic                    frozen;
    logic                    refused;
    logic [31:0]             rd_value;

    slpr_layout_if lay ();

    // one wait cycle per access: the first edge captures read data, the second completes
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_ff;
    assign wr_take         = avs_write & ack_ff;
    assign avs_readdata    = readdata_ff;

    // only the low byte lane carries register bits
    assign wr_nv     = wr_take & avs_byteenable[0] & (avs_address == `SLPR_OFF_CFG_NV);
    assign wr_vol    = wr_take & avs_byteenable[0] & (avs_address == `SLPR_OFF_CFG_VOL);
    assign wr_status = wr_take & avs_byteenable[0] & (avs_address == `SLPR_OFF_IRQ_STATUS);
    assign wr_mask   = wr_take & avs_byteenable[0] & (avs_address == `SLPR_OFF_IRQ_MASK);
    assign wr_cfg    = slpr_pkg::slpr_cfg_t'(avs_writedata[7:0]);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    // suspend flags follow the operation state with one register stage
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            erase_susp_ff <= 1'b0;
            prog_susp_ff  <= 1'b0;
        end
        else
        begin
            erase_susp_ff <= erase_suspended;
            prog_susp_ff  <= program_suspended;
        end
    end

    // either lock in the volatile copy, or the permanent lock in the non-volatile copy, freezes the layout bits
    assign frozen        = cfg_vol_ff.plock | cfg_vol_ff.tlock | cfg_nv_ff.plock;
    assign layout_locked = frozen;

    always_comb
    begin
        nxt_cfg_nv = cfg_nv_ff;
        refused    = 1'b0;
        if (wr_nv)
        begin
            nxt_cfg_nv.rsvd7 = wr_cfg.rsvd7;
            nxt_cfg_nv.rsvd3 = wr_cfg.rsvd3;
            nxt_cfg_nv.rsvd1 = wr_cfg.rsvd1;
            if (frozen)
            begin
                // a write that would alter a frozen bit keeps the frozen bits and is flagged; reserved bits and the lock still update
                refused = ((wr_cfg ^ cfg_nv_ff) & `SLPR_LAYOUT_MASK) != 8'h00;
            end
            else
            begin
                nxt_cfg_nv.split  = wr_cfg.split;
                nxt_cfg_nv.half   = wr_cfg.half;
                nxt_cfg_nv.topbot = wr_cfg.topbot;
            end
            nxt_cfg_nv.plock = cfg_nv_ff.plock | wr_cfg.plock;
            if (cfg_nv_ff.plock & ~wr_cfg.plock)
                refused = 1'b1;
            // non-volatile temporary lock copy never changes from software
            nxt_cfg_nv.tlock = cfg_nv_ff.tlock;
        end
    end

    // reset stands in for power-on; real retention would come from the array
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cfg_nv_ff <= slpr_pkg::slpr_cfg_t'(`SLPR_CFG_NV_RESET);
        else
            cfg_nv_ff <= nxt_cfg_nv;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            load_pending_ff <= 1'b1;
        else
            load_pending_ff <= 1'b0;
    end

    // the async reset may only load a constant, so the copy happens on the first edge after release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cfg_vol_ff <= slpr_pkg::slpr_cfg_t'(`SLPR_CFG_VOL_RESET);
        else if (load_pending_ff)
            cfg_vol_ff <= cfg_nv_ff;
        else if (wr_vol)
        begin
            cfg_vol_ff.tlock <= wr_cfg.tlock;
            cfg_vol_ff.rsvd7 <= wr_cfg.rsvd7;
            cfg_vol_ff.rsvd3 <= wr_cfg.rsvd3;
            cfg_vol_ff.rsvd1 <= wr_cfg.rsvd1;
        end
    end

    // layout seen by the decoder is the volatile copy, fixed between resets
    assign lay.split_small_sectors    = cfg_vol_ff.split;
    assign lay.small_block_top_bottom = cfg_vol_ff.topbot;
    assign lay.readable_half_select   = cfg_vol_ff.half;

    slpr_layout_decode #(
        .ADDR_W      (ADDR_W),
        .SMALL_LOG2  (SMALL_LOG2),
        .SMALL_COUNT (SMALL_COUNT)
    ) u_decode (
        .lay             (lay),
        .probe_addr      (probe_addr),
        .password_ok     (password_ok),
        .in_small_sector (in_small_sector),
        .readable        (readable)
    );

    // events: entry into erase suspend, entry into program suspend, refused layout write
    assign irq_events[`SLPR_IRQ_ERASE_SUSP] = erase_suspended & ~erase_susp_ff;
    assign irq_events[`SLPR_IRQ_PROG_SUSP]  = program_suspended & ~prog_susp_ff;
    assign irq_events[`SLPR_IRQ_REFUSED]    = refused;
    assign irq_clear = wr_status ? avs_writedata[`SLPR_IRQ_W-1:0] : {`SLPR_IRQ_W{1'b0}};

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_status_ff <= {`SLPR_IRQ_W{1'b0}};
        else
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_mask_ff <= `SLPR_IRQ_MASK_RESET;
        else if (wr_mask)
            irq_mask_ff <= avs_writedata[`SLPR_IRQ_W-1:0];
    end

    assign irq = |(irq_status_ff & irq_mask_ff);

    // suspend bits are only meaningful to the host while device_busy reads 0
    always_comb
    begin
        rd_value = 32'h0000_0000;
        unique case (avs_address)
            `SLPR_OFF_SUSPEND:
            begin
                rd_value[`SLPR_BIT_ERASE_SUSP] = erase_susp_ff;
                rd_value[`SLPR_BIT_PROG_SUSP]  = prog_susp_ff;
            end
            `SLPR_OFF_CFG_NV:     rd_value[7:0] = cfg_nv_ff;
            `SLPR_OFF_CFG_VOL:    rd_value[7:0] = cfg_vol_ff;
            `SLPR_OFF_IRQ_STATUS: rd_value[`SLPR_IRQ_W-1:0] = irq_status_ff;
            `SLPR_OFF_IRQ_MASK:   rd_value[`SLPR_IRQ_W-1:0] = irq_mask_ff;
            `SLPR_OFF_DEV_STATE:
            begin
                rd_value[0] = device_busy;
                rd_value[1] = frozen;
                rd_value[2] = load_pending_ff;
            end
            default:              rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            readdata_ff <= 32'h0000_0000;
        else if (avs_read & ~ack_ff)
            readdata_ff <= rd_value;
    end

endmodule

`default_nettype wire

// ==== testbench/slpr_regs_checker.sv ====
// assertion checker for the layout/suspend register bank, bound to slpr_regs
// assumes one clock and an async active-low reset on the bank's own ports
`timescale 1ns/1ps
`default_nettype none

module slpr_regs_checker #(
    parameter int ADDR_W      = 26,
    parameter int SMALL_LOG2  = 12,
    parameter int SMALL_COUNT = 32
) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic [7:0]        avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              erase_suspended,
    input wire logic              program_suspended,
    input wire logic              device_busy,
    input wire logic              password_ok,
    input wire logic              readable,
    input wire logic              layout_locked
);
    logic       rd_done;
    logic [1:0] susp;
    assign rd_done = avs_read && !avs_waitrequest;
    assign susp    = {erase_suspended, program_suspended};

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("new request was not held off");
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait raised without request");
    // the status copy lags its input, so only compare once the input has settled
    a_suspend_read: assert property (rd_done && avs_address == 8'h00 && $stable(susp)
        && $past(susp, 2) == susp && $past(susp, 3) == susp |-> avs_readdata[1:0] == susp)
        else $error("suspend flags read wrong");
    a_busy_read: assert property (rd_done && avs_address == 8'h14 && $stable(device_busy)
        |-> avs_readdata[0] == device_busy)
        else $error("busy bit read wrong");
    a_lock_read: assert property (rd_done && avs_address == 8'h14 && $stable(layout_locked)
        |-> avs_readdata[1] == layout_locked)
        else $error("lock state read wrong");
    a_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_unmapped_zero: assert property (rd_done && avs_address > 8'h14 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_pw_readable: assert property (password_ok |-> readable)
        else $error("unlocked address not readable");
endmodule

bind slpr_regs slpr_regs_checker #(.ADDR_W(ADDR_W), .SMALL_LOG2(SMALL_LOG2), .SMALL_COUNT(SMALL_COUNT)) i_chk (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .erase_suspended(erase_suspended),
    .program_suspended(program_suspended), .device_busy(device_busy), .password_ok(password_ok),
    .readable(readable), .layout_locked(layout_locked));

`default_nettype wire

// ==== testbench/slpr_engine_model.sv ====
// erase/program engine model: enters or leaves suspend partway through a short busy phase
// assumes the bench sets the wanted suspend state as levels on clk
`timescale 1ns/1ps
`default_nettype none

module slpr_engine_model (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic want_erase,
    input  wire logic want_prog,
    output logic      erase_suspended,
    output logic      program_suspended,
    output logic      device_busy
);
    logic [2:0] cnt_ff;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_ff            <= 3'h0;
            erase_suspended   <= 1'b0;
            program_suspended <= 1'b0;
        end
        else if (cnt_ff != 3'h0)
        begin
            cnt_ff <= cnt_ff - 3'h1;
            if (cnt_ff == 3'h3)
            begin
                erase_suspended   <= want_erase;
                program_suspended <= want_prog;
            end
        end
        else if ({want_erase, want_prog} != {erase_suspended, program_suspended})
            cnt_ff <= 3'h5;
    end

    // busy outlasts the flag change so an idle host never sees a stale copy
    assign device_busy = (cnt_ff != 3'h0);
endmodule

`default_nettype wire

// ==== testbench/tb_sector_layout_protect_regs.sv ====
// self-checking bench for the layout/suspend register bank over avalon-mm
// assumes 50 MHz clock; nv settings do not survive reset in this bank
`timescale 1ns/1ps
`default_nettype none

module tb_sector_layout_protect_regs;
    logic        clk, reset_n, avs_read, avs_write, want_erase, want_prog, password_ok;
    logic        avs_waitrequest, erase_suspended, program_suspended, device_busy;
    logic        in_small_sector, readable, layout_locked, irq;
    logic [7:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [25:0] probe_addr;
    int          n_fail, n_tests;

    slpr_regs i_dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .erase_suspended(erase_suspended),
        .program_suspended(program_suspended), .device_busy(device_busy), .probe_addr(probe_addr),
        .password_ok(password_ok), .in_small_sector(in_small_sector), .readable(readable),
        .layout_locked(layout_locked), .irq(irq));

    slpr_engine_model i_eng (.clk(clk), .reset_n(reset_n), .want_erase(want_erase), .want_prog(want_prog),
        .erase_suspended(erase_suspended), .program_suspended(program_suspended), .device_busy(device_busy));

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // called just after a rising edge; waitrequest and read data are taken at the same rising edge,
    // then one idle cycle follows so strobes never toggle twice in one time step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (avs_waitrequest !== 1'b0 && i < 20);
        if (i >= 20)
        begin
            n_fail++;
            end_sim();
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic pr(input logic [25:0] a, input logic p, input logic [31:0] e);
        probe_addr  <= a;
        password_ok <= p;
        @(negedge clk);
        chk({30'h0, in_small_sector, readable}, e);
        @(posedge clk);
    endtask

    // the engine only sees a new request level one edge later, so let busy rise before polling
    task automatic wait_idle;
        int i;
        i = 0;
        repeat (2) @(posedge clk);
        do
        begin
            bus(1'b0, 8'h14, 32'h0);
            i++;
        end
        while (q[0] !== 1'b0 && i < 40);
        chk({31'h0, q[0]}, 32'h0);
    endtask

    task automatic pulse_reset;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        {reset_n, avs_read, avs_write, want_erase, want_prog, password_ok} = 6'h0;
        avs_address = 8'h0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        probe_addr = 26'h0;
        n_fail = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'h10, 32'h0);
        wr(8'h18, 32'hff);
        rd(8'h18, 32'h0);
        pr(26'h001ffff, 1'b0, 32'h2);
        pr(26'h0020000, 1'b0, 32'h0);
        pr(26'h3ffffff, 1'b0, 32'h1);
        pr(26'h0000000, 1'b1, 32'h3);
        wr(8'h04, 32'h64);
        rd(8'h04, 32'h64);
        rd(8'h08, 32'h0);
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h1);
        rd(8'h14, 32'h2);
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h64);
        rd(8'h0c, 32'h4);
        wr(8'h10, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(8'h0c, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(8'h08, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h04, 32'h74);
        rd(8'h04, 32'h74);
        wr(8'h04, 32'h01);
        rd(8'h04, 32'h74);
        rd(8'h14, 32'h2);
        wr(8'h08, 32'h1);
        pulse_reset();
        wait_idle();
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h0);
        want_erase <= 1'b1;
        wait_idle();
        rd(8'h00, 32'h2);
        want_prog <= 1'b1;
        wait_idle();
        rd(8'h00, 32'h3);
        rd(8'h0c, 32'h3);
        {want_erase, want_prog} <= 2'h0;
        wait_idle();
        rd(8'h00, 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire
